// >>> mfid_pkg.sv
package mfid_pkg;

    // ****************************************************************
    // Bus shape
    // ****************************************************************
    localparam int MFID_AW = 12;
    localparam int MFID_DW = 32;
    localparam int MFID_NUM_PAGES = 4;

    // ****************************************************************
    // Register offsets within one feature page
    // ****************************************************************
    localparam logic [MFID_AW-1:0] MFID_OFF_FEAT_ID = 12'h080;
    localparam logic [MFID_AW-1:0] MFID_OFF_BW_ID = 12'h090;
    localparam logic [MFID_AW-1:0] MFID_OFF_PART_SEL = 12'h100;
    localparam logic [MFID_AW-1:0] MFID_OFF_MON_SEL = 12'h104;

    // ****************************************************************
    // Field layout of the monitoring feature word
    // ****************************************************************
    localparam int MFID_B_LOCAL_CAPT = 31;
    localparam int MFID_B_NO_WIRED_IRQ = 30;
    localparam int MFID_B_MSG_IRQ = 29;
    localparam int MFID_B_OFLW_SR = 28;
    localparam int MFID_B_BW_MON = 17;
    localparam int MFID_B_CSU_MON = 16;

    // ****************************************************************
    // Selector registers and instances
    // ****************************************************************
    localparam int MFID_INST_W = 4;
    localparam int MFID_INST_LSB = 24;
    localparam int MFID_NUM_INST = 4;
    localparam int MFID_SEL_W = 2;
    localparam int MFID_ID_W = 16;
    localparam int MFID_MON_CNT_W = 16;
    localparam logic [MFID_INST_W-1:0] MFID_INST_LIMIT = 4'h4;
    localparam logic [MFID_INST_W-1:0] MFID_INST_ZERO = 4'h0;
    localparam logic [MFID_ID_W-1:0] MFID_ID_RST = 16'h0000;
    localparam logic [MFID_DW-1:0] MFID_WORD_ZERO = 32'h00000000;

    typedef enum logic [1:0] {
        MFID_PG_SECURE = 2'h0,
        MFID_PG_NONSECURE = 2'h1,
        MFID_PG_ROOT = 2'h2,
        MFID_PG_REALM = 2'h3
    } mfid_page_e;

endpackage

// >>> mfid_id_if.sv
`timescale 1ns/1ps
interface mfid_id_if;
    import mfid_pkg::*;
    logic [MFID_INST_W-1:0] inst;
    logic [MFID_DW-1:0] feat_word;
    logic [MFID_DW-1:0] bw_word;

    modport host (output inst, input feat_word, input bw_word);
    modport feat (input inst, output feat_word);
    modport bw (input inst, output bw_word);
endinterface

// >>> mfid_feat_word.sv
`timescale 1ns/1ps
module mfid_feat_word #(
    parameter bit MON_PRESENT = 1'b1,
    parameter bit V11 = 1'b1,
    parameter bit LOCAL_CAPT = 1'b1,
    parameter bit NO_WIRED_IRQ = 1'b0,
    parameter bit MSG_IRQ = 1'b1,
    parameter bit OFLW_SR = 1'b1,
    parameter logic [3:0] BW_MASK = 4'hF,
    parameter logic [3:0] CSU_MASK = 4'h5
) (
    mfid_id_if.feat idf
);
    import mfid_pkg::*;

    logic inst_ok;
    logic [MFID_DW-1:0] word;

    assign inst_ok = idf.inst < MFID_INST_LIMIT;

    always_comb begin
        word = MFID_WORD_ZERO;
        if (MON_PRESENT) begin
            word[MFID_B_LOCAL_CAPT] = LOCAL_CAPT;
            // Overflow capability bits exist only with the v1.1 extension
            if (V11) begin
                word[MFID_B_NO_WIRED_IRQ] = NO_WIRED_IRQ;
                word[MFID_B_MSG_IRQ] = MSG_IRQ;
                word[MFID_B_OFLW_SR] = OFLW_SR;
            end
            // Unimplemented instances report neither bandwidth nor CSU monitoring
            if (inst_ok) begin
                word[MFID_B_BW_MON] = BW_MASK[idf.inst[MFID_SEL_W-1:0]];
                word[MFID_B_CSU_MON] = CSU_MASK[idf.inst[MFID_SEL_W-1:0]];
            end
        end
    end

    assign idf.feat_word = word;
endmodule // mfid_feat_word

// >>> mfid_bw_word.sv
`timescale 1ns/1ps
module mfid_bw_word #(
    parameter bit MON_PRESENT = 1'b1,
    parameter logic [3:0] BW_MASK = 4'hF,
    parameter logic [63:0] MON_COUNTS = 64'h0004000800100020
) (
    mfid_id_if.bw idb
);
    import mfid_pkg::*;

    logic [MFID_SEL_W-1:0] sel;
    logic present;
    logic [MFID_MON_CNT_W-1:0] count;

    assign sel = idb.inst[MFID_SEL_W-1:0];
    assign present = MON_PRESENT && (idb.inst < MFID_INST_LIMIT) && BW_MASK[sel];
    assign count = MON_COUNTS[sel*MFID_MON_CNT_W +: MFID_MON_CNT_W];

    always_comb begin
        idb.bw_word = MFID_WORD_ZERO;
        // Absent bandwidth monitoring leaves the whole word at zero
        if (present) begin
            idb.bw_word[MFID_MON_CNT_W-1:0] = count;
        end
    end
endmodule // mfid_bw_word

// >>> mfid_top.sv
`timescale 1ns/1ps
module mfid_top #(
    parameter bit MON_PRESENT = 1'b1,
    parameter bit MULTI_INST = 1'b1,
    parameter bit REALM_EXT = 1'b1,
    parameter bit V11 = 1'b1,
    parameter bit LOCAL_CAPT = 1'b1,
    parameter bit NO_WIRED_IRQ = 1'b0,
    parameter bit MSG_IRQ = 1'b1,
    parameter bit OFLW_SR = 1'b1,
    parameter logic [3:0] BW_MASK = 4'hF,
    parameter logic [3:0] CSU_MASK = 4'h5,
    parameter logic [63:0] MON_COUNTS = 64'h0004000800100020
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic req_valid,
    input wire logic req_write,
    input wire mfid_pkg::mfid_page_e req_page,
    input wire logic [mfid_pkg::MFID_AW-1:0] req_addr,
    input wire logic [mfid_pkg::MFID_DW-1:0] req_wdata,
    output logic rsp_valid,
    output logic [mfid_pkg::MFID_DW-1:0] rsp_rdata,
    output logic rsp_wr_ignored,
    output logic oflw_wired_irq_en,
    output logic oflw_msg_irq_en
);
    import mfid_pkg::*;

    // ****************************************************************
    // Reset release
    // ****************************************************************
    logic rst_meta_r;
    logic rst_sync_b_r;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_r <= 1'b0;
            rst_sync_b_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_b_r <= rst_meta_r;
        end
    end

    // ****************************************************************
    // Request decode
    // ****************************************************************
    logic page_ok;
    logic hit_feat;
    logic hit_bw;
    logic hit_part;
    logic hit_mon;
    logic rd_req;
    logic wr_req;

    // Root and realm pages only answer when the realm extension exists
    assign page_ok = REALM_EXT || (req_page == MFID_PG_SECURE) ||
                     (req_page == MFID_PG_NONSECURE);
    assign hit_feat = page_ok && (req_addr == MFID_OFF_FEAT_ID);
    assign hit_bw = page_ok && (req_addr == MFID_OFF_BW_ID);
    assign hit_part = page_ok && (req_addr == MFID_OFF_PART_SEL);
    assign hit_mon = page_ok && (req_addr == MFID_OFF_MON_SEL);
    assign rd_req = req_valid && !req_write;
    assign wr_req = req_valid && req_write;

    // ****************************************************************
    // Per-page selector registers
    // ****************************************************************
    logic [MFID_INST_W-1:0] part_inst_r [MFID_NUM_PAGES];
    logic [MFID_ID_W-1:0] part_id_r [MFID_NUM_PAGES];
    logic [MFID_INST_W-1:0] mon_inst_r [MFID_NUM_PAGES];
    logic [MFID_ID_W-1:0] mon_sel_r [MFID_NUM_PAGES];

    // Each page keeps its own selectors, so copies may differ per page
    for (genvar pg = 0; pg < MFID_NUM_PAGES; pg++) begin : g_page
        logic page_hit;
        assign page_hit = wr_req && (req_page == mfid_page_e'(pg));

        always_ff @(posedge mclk or negedge rst_sync_b_r) begin
            if (!rst_sync_b_r) begin
                part_inst_r[pg] <= MFID_INST_ZERO;
                part_id_r[pg] <= MFID_ID_RST;
            end else if (page_hit && hit_part) begin
                // Instance field is held at zero on single-instance parts
                part_inst_r[pg] <= MULTI_INST ?
                    req_wdata[MFID_INST_LSB +: MFID_INST_W] : MFID_INST_ZERO;
                part_id_r[pg] <= req_wdata[MFID_ID_W-1:0];
            end
        end

        always_ff @(posedge mclk or negedge rst_sync_b_r) begin
            if (!rst_sync_b_r) begin
                mon_inst_r[pg] <= MFID_INST_ZERO;
                mon_sel_r[pg] <= MFID_ID_RST;
            end else if (page_hit && hit_mon) begin
                mon_inst_r[pg] <= req_wdata[MFID_INST_LSB +: MFID_INST_W];
                mon_sel_r[pg] <= req_wdata[MFID_ID_W-1:0];
            end
        end
    end

    // ****************************************************************
    // Identification words
    // ****************************************************************
    mfid_id_if idw ();

    // Only the partition-select instance steers the ID words
    assign idw.inst = part_inst_r[req_page];

    mfid_feat_word #(
        .MON_PRESENT(MON_PRESENT),
        .V11(V11),
        .LOCAL_CAPT(LOCAL_CAPT),
        .NO_WIRED_IRQ(NO_WIRED_IRQ),
        .MSG_IRQ(MSG_IRQ),
        .OFLW_SR(OFLW_SR),
        .BW_MASK(BW_MASK),
        .CSU_MASK(CSU_MASK)
    ) u_feat (
        .idf(idw.feat)
    );

    mfid_bw_word #(
        .MON_PRESENT(MON_PRESENT),
        .BW_MASK(BW_MASK),
        .MON_COUNTS(MON_COUNTS)
    ) u_bw (
        .idb(idw.bw)
    );

    // ****************************************************************
    // Read data selection
    // ****************************************************************
    logic [MFID_DW-1:0] rdata_nxt;

    always_comb begin
        rdata_nxt = MFID_WORD_ZERO;
        if (hit_feat) begin
            rdata_nxt = idw.feat_word;
        end else if (hit_bw) begin
            rdata_nxt = idw.bw_word;
        end else if (hit_part) begin
            rdata_nxt[MFID_INST_LSB +: MFID_INST_W] = part_inst_r[req_page];
            rdata_nxt[MFID_ID_W-1:0] = part_id_r[req_page];
        end else if (hit_mon) begin
            rdata_nxt[MFID_INST_LSB +: MFID_INST_W] = mon_inst_r[req_page];
            rdata_nxt[MFID_ID_W-1:0] = mon_sel_r[req_page];
        end
    end

    // ****************************************************************
    // Response
    // ****************************************************************
    always_ff @(posedge mclk or negedge rst_sync_b_r) begin
        if (!rst_sync_b_r) begin
            rsp_valid <= 1'b0;
        end else begin
            rsp_valid <= req_valid;
        end
    end

    always_ff @(posedge mclk or negedge rst_sync_b_r) begin
        if (!rst_sync_b_r) begin
            rsp_rdata <= MFID_WORD_ZERO;
        end else if (rd_req) begin
            rsp_rdata <= rdata_nxt;
        end else if (wr_req) begin
            rsp_rdata <= MFID_WORD_ZERO;
        end
    end

    // A write to either ID word or an unmapped slot changes nothing
    always_ff @(posedge mclk or negedge rst_sync_b_r) begin
        if (!rst_sync_b_r) begin
            rsp_wr_ignored <= 1'b0;
        end else begin
            rsp_wr_ignored <= wr_req && !hit_part && !hit_mon;
        end
    end

    // ****************************************************************
    // Overflow signalling capability
    // ****************************************************************
    // The overflow logic elsewhere in the component gates its interrupt
    // paths with these, so what it does matches bit 29 always, and bit 30 only with monitoring and the v1.1 extension present.
    always_ff @(posedge mclk or negedge rst_sync_b_r) begin
        if (!rst_sync_b_r) begin
            oflw_wired_irq_en <= 1'b0;
            oflw_msg_irq_en <= 1'b0;
        end else begin
            oflw_wired_irq_en <= MON_PRESENT && V11 && !NO_WIRED_IRQ;
            oflw_msg_irq_en <= MON_PRESENT && V11 && MSG_IRQ;
        end
    end

endmodule // mfid_top

// >>> mfid_top_properties.sv
`timescale 1ns/1ps
module mfid_top_properties (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic req_valid,
    input wire logic req_write,
    input wire mfid_pkg::mfid_page_e req_page,
    input wire logic [mfid_pkg::MFID_AW-1:0] req_addr,
    input wire logic [mfid_pkg::MFID_DW-1:0] req_wdata,
    input wire logic rsp_valid,
    input wire logic [mfid_pkg::MFID_DW-1:0] rsp_rdata,
    input wire logic rsp_wr_ignored,
    input wire logic oflw_wired_irq_en,
    input wire logic oflw_msg_irq_en
);
    import mfid_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    sequence s_feat_rd;
        req_valid && !req_write && req_addr == MFID_OFF_FEAT_ID;
    endsequence
    // ****************************************************************
    // Port timing and write refusal
    // ****************************************************************
    property p_rsp_follows_req;
        req_valid |=> rsp_valid;
    endproperty
    a_rsp_follows_req: assert property (p_rsp_follows_req)
        else $error("no response one cycle after a request");
    property p_no_stray_rsp;
        !req_valid |=> !rsp_valid;
    endproperty
    a_no_stray_rsp: assert property (p_no_stray_rsp)
        else $error("response without a request");
    property p_id_write_ignored;
        req_valid && req_write && (req_addr == MFID_OFF_FEAT_ID || req_addr == MFID_OFF_BW_ID)
            |=> rsp_wr_ignored && rsp_rdata == MFID_WORD_ZERO;
    endproperty
    a_id_write_ignored: assert property (p_id_write_ignored)
        else $error("write to an id word was not refused");
    property p_ignored_has_cause;
        rsp_wr_ignored |-> $past(req_valid && req_write);
    endproperty
    a_ignored_has_cause: assert property (p_ignored_has_cause)
        else $error("refusal flag without a write");
    property p_rdata_holds;
        !req_valid |=> $stable(rsp_rdata);
    endproperty
    a_rdata_holds: assert property (p_rdata_holds)
        else $error("read data moved without a request");
    // ****************************************************************
    // Word contents
    // ****************************************************************
    property p_feat_reserved;
        s_feat_rd |=> rsp_rdata[27:18] == 10'h000 && rsp_rdata[15:0] == 16'h0000;
    endproperty
    a_feat_reserved: assert property (p_feat_reserved)
        else $error("reserved feature bits not zero");
    property p_bw_upper_zero;
        req_valid && !req_write && req_addr == MFID_OFF_BW_ID |=> rsp_rdata[31:16] == 16'h0000;
    endproperty
    a_bw_upper_zero: assert property (p_bw_upper_zero)
        else $error("bandwidth id upper half not zero");
    property p_msg_bit;
        s_feat_rd |=> rsp_rdata[MFID_B_MSG_IRQ] == oflw_msg_irq_en;
    endproperty
    a_msg_bit: assert property (p_msg_bit)
        else $error("message irq bit disagrees with its enable");
    property p_wired_bit;
        s_feat_rd ##1 oflw_wired_irq_en |-> !rsp_rdata[MFID_B_NO_WIRED_IRQ];
    endproperty
    a_wired_bit: assert property (p_wired_bit)
        else $error("wired irq bit set while wired irq enabled");
endmodule // mfid_top_properties

bind mfid_top mfid_top_properties u_props (.mclk(mclk), .rst_b(rst_b), .req_valid(req_valid),
    .req_write(req_write), .req_page(req_page), .req_addr(req_addr), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_wr_ignored(rsp_wr_ignored),
    .oflw_wired_irq_en(oflw_wired_irq_en), .oflw_msg_irq_en(oflw_msg_irq_en));

// >>> mfid_top_tb.sv
`timescale 1ns/1ps
module mfid_top_tb;
    import mfid_pkg::*;
    localparam logic [3:0] BW_M = 4'hF;
    localparam logic [3:0] CSU_M = 4'h5;
    localparam logic [63:0] CNTS = 64'h0004000800100020;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    mfid_page_e req_page = MFID_PG_SECURE;
    logic [MFID_AW-1:0] req_addr = 12'h000;
    logic [MFID_DW-1:0] req_wdata = 32'h00000000;
    logic rsp_valid, rsp_wr_ignored, wired_en, msg_en, ign;
    logic [MFID_DW-1:0] rsp_rdata, rdata_b, rd, rd_b;
    logic wired_n, msg_n, ign_n, ign_nirq;
    logic [MFID_DW-1:0] rdata_n, rdata_o, rd_n, rd_o;
    int fail_count = 0;
    int samples_checked = 0;
    always #12.5 mclk = ~mclk;
    mfid_top u_dut (.mclk(mclk), .rst_b(rst_b), .req_valid(req_valid), .req_write(req_write),
        .req_page(req_page), .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .rsp_wr_ignored(rsp_wr_ignored), .oflw_wired_irq_en(wired_en),
        .oflw_msg_irq_en(msg_en));
    // Reduced build shares the stimulus so both builds see identical selector state
    mfid_top #(.V11(1'b0), .LOCAL_CAPT(1'b0)) u_dut_min (.mclk(mclk), .rst_b(rst_b),
        .req_valid(req_valid), .req_write(req_write), .req_page(req_page), .req_addr(req_addr),
        .req_wdata(req_wdata), .rsp_valid(), .rsp_rdata(rdata_b), .rsp_wr_ignored(),
        .oflw_wired_irq_en(), .oflw_msg_irq_en());
    // Single instance, no overflow interrupts, root and realm pages absent
    mfid_top #(.MULTI_INST(1'b0), .REALM_EXT(1'b0), .NO_WIRED_IRQ(1'b1), .MSG_IRQ(1'b0))
        u_dut_nirq (.mclk(mclk), .rst_b(rst_b), .req_valid(req_valid), .req_write(req_write),
        .req_page(req_page), .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(),
        .rsp_rdata(rdata_n), .rsp_wr_ignored(ign_nirq), .oflw_wired_irq_en(wired_n),
        .oflw_msg_irq_en(msg_n));
    // Monitoring absent: both id words must read zero
    mfid_top #(.MON_PRESENT(1'b0)) u_dut_off (.mclk(mclk), .rst_b(rst_b),
        .req_valid(req_valid), .req_write(req_write), .req_page(req_page), .req_addr(req_addr),
        .req_wdata(req_wdata), .rsp_valid(), .rsp_rdata(rdata_o), .rsp_wr_ignored(),
        .oflw_wired_irq_en(), .oflw_msg_irq_en());
    // ****************************************************************
    // Access and compare helpers
    // ****************************************************************
    task automatic check(input logic [MFID_DW-1:0] got, input logic [MFID_DW-1:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic access(input logic wr, input int pg, input logic [MFID_AW-1:0] a,
                          input logic [MFID_DW-1:0] wd);
        @(posedge mclk);
        req_valid <= 1'b1;
        req_write <= wr;
        req_page <= mfid_page_e'(pg);
        req_addr <= a;
        req_wdata <= wd;
        @(posedge mclk);
        req_valid <= 1'b0;
        #1;
        check({31'h0, rsp_valid}, 32'h1);
        rd = rsp_rdata;
        rd_b = rdata_b;
        ign = rsp_wr_ignored;
        ign_n = ign_nirq;
        rd_n = rdata_n;
        rd_o = rdata_o;
    endtask
    function automatic logic [MFID_DW-1:0] feat_exp(input int i, input bit full);
        logic [MFID_DW-1:0] w;
        w = full ? 32'hB0000000 : 32'h00000000;
        if (i < 4) begin
            w[MFID_B_BW_MON] = BW_M[i];
            w[MFID_B_CSU_MON] = CSU_M[i];
        end
        return w;
    endfunction
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        check({30'h0, wired_en, msg_en}, 32'h3);
        check({30'h0, wired_n, msg_n}, 32'h0);
        for (int p = 0; p < 4; p++) begin
            for (int i = 0; i < 6; i++) begin
                access(1'b1, p, MFID_OFF_PART_SEL, 32'(i) << MFID_INST_LSB);
                check({31'h0, ign}, 32'h0);
                check({31'h0, ign_n}, 32'(p >= 2));
                access(1'b0, p, MFID_OFF_FEAT_ID, 32'h0);
                check(rd, feat_exp(i, 1'b1));
                check(rd_b, feat_exp(i, 1'b0));
                check(rd_n, (p < 2) ? 32'hD0030000 : 32'h0);
                check(rd_o, 32'h0);
                access(1'b0, p, MFID_OFF_BW_ID, 32'h0);
                check(rd, (i < 4) ? {16'h0, CNTS[i*16 +: 16]} : 32'h0);
                check(rd_n, (p < 2) ? 32'h00000020 : 32'h0);
                check(rd_o, 32'h0);
            end
        end
        access(1'b1, 0, MFID_OFF_PART_SEL, 32'h01000000);
        access(1'b0, 1, MFID_OFF_FEAT_ID, 32'h0);
        check(rd, feat_exp(5, 1'b1));
        access(1'b0, 0, MFID_OFF_PART_SEL, 32'h0);
        check(rd, 32'h01000000);
        check(rd_n, 32'h0);
        access(1'b1, 0, MFID_OFF_MON_SEL, 32'h03000000);
        access(1'b0, 0, MFID_OFF_BW_ID, 32'h0);
        check(rd, 32'h00000010);
        // Writes to id words must leave the reported value untouched
        access(1'b1, 0, MFID_OFF_FEAT_ID, 32'hFFFFFFFF);
        check({31'h0, ign}, 32'h1);
        check(rd, 32'h0);
        access(1'b1, 0, MFID_OFF_BW_ID, 32'hFFFFFFFF);
        check({31'h0, ign}, 32'h1);
        access(1'b0, 0, MFID_OFF_FEAT_ID, 32'h0);
        check(rd, feat_exp(1, 1'b1));
        access(1'b0, 0, MFID_OFF_BW_ID, 32'h0);
        check(rd, 32'h00000010);
        access(1'b1, 3, 12'h0F0, 32'hA5A5A5A5);
        check({31'h0, ign}, 32'h1);
        access(1'b0, 3, 12'h0F0, 32'h0);
        check(rd, 32'h0);
        close_out();
    end
    initial begin
        repeat (5000) @(posedge mclk);
        fail_count++;
        close_out();
    end
endmodule // mfid_top_tb
